// *** tb_watchdog_timeout_unit.sv ***
// self-checking bench for the watchdog timeout unit
`timescale 1ns/100ps
module tb_watchdog_timeout_unit;
  import wd_timeout_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, sys_stat;
  logic refresh, dbg, stop, ao, rsp, exc, rst, rec, wdf, stf;
  logic [4:0] ev;
  logic [3:0] wstrb;
  int num_errors, tests_run, cyc, n;

  assign ev = {exc, rst, rec, wdf, stf};

  watchdog_timeout_unit #(.TICK_DIV(4)) u_watchdog_timeout_unit (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .refresh_instr(refresh), .debug_mode(dbg), .stop_mode(stop), .always_on_option(ao),
    .timeout_response_option(rsp), .exception_req(exc), .reset_req(rst),
    .stop_recovery_req(rec), .wd_flag_set(wdf), .stop_flag_set(stf)
  );

  wd_sys_model u_wd_sys_model (
    .aclk(aclk), .aresetn(aresetn), .wd_flag_set(wdf), .stop_flag_set(stf),
    .rst_status_q(sys_stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a ceiling on the whole run
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compares and reporting
  task chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task summarize();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // bus cycles: hold each channel until its own handshake
  task axi_wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk_resp(bresp, er);
  endtask : axi_wr

  task axi_rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk_data(rdata, ed);
    chk_resp(rresp, er);
  endtask : axi_rd

  // one-cycle refresh instruction from the cpu
  task kick();
    @(posedge aclk);
    refresh <= 1'h1;
    @(posedge aclk);
    refresh <= 1'h0;
  endtask : kick

  // cycles until any timeout pulse, lim + 1 if none came
  task wait_pulse(input int lim, output int cnt);
    cnt = 0;
    repeat (lim) begin
      @(negedge aclk);
      cnt++;
      if (|ev) return;
    end
    cnt = lim + 1;
  endtask : wait_pulse

  // skip the pulse that may still follow a mode change
  task second_pulse(output int cnt);
    wait_pulse(100, cnt);
    wait_pulse(100, cnt);
  endtask : second_pulse

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {refresh, dbg, stop, ao, rsp} = 5'h00;
    awaddr = 14'h0000;
    araddr = 14'h0000;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    cyc = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values, unmapped place, idle before enable
    axi_rd(RELOAD_HI_ADDR, 32'h0000_0400, RESP_OKAY);
    axi_rd(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    axi_rd(14'h0010, 32'h0000_0000, RESP_SLVERR);
    axi_wr(14'h0010, 8'h12, RESP_SLVERR);
    repeat (40) @(posedge aclk);
    axi_rd(RELOAD_LO_ADDR, 32'h0000_0400, RESP_OKAY);
    $display("test reset done");
    // unlock sequence with oscillator stopped so the count stands
    axi_wr(CTRL_ADDR, 8'h00, RESP_OKAY);
    // a write with its byte strobe off leaves the oscillator stopped
    wstrb <= 4'h0;
    axi_wr(CTRL_ADDR, 8'h01, RESP_OKAY);
    wstrb <= 4'h1;
    axi_rd(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
    axi_wr(RELOAD_HI_ADDR, 8'h12, RESP_OKAY);
    axi_wr(RELOAD_LO_ADDR, 8'h34, RESP_OKAY);
    kick();
    axi_rd(RELOAD_HI_ADDR, 32'h0000_0400, RESP_OKAY);
    axi_wr(RELOAD_HI_ADDR, UNLOCK_KEY1, RESP_OKAY);
    axi_wr(RELOAD_HI_ADDR, UNLOCK_KEY2, RESP_OKAY);
    kick();
    axi_rd(RELOAD_HI_ADDR, 32'h0000_0400, RESP_OKAY);
    axi_wr(RELOAD_HI_ADDR, 8'h00, RESP_OKAY);
    axi_wr(RELOAD_LO_ADDR, 8'h03, RESP_OKAY);
    kick();
    axi_rd(RELOAD_LO_ADDR, 32'h0000_0003, RESP_OKAY);
    axi_wr(RELOAD_LO_ADDR, 8'h07, RESP_OKAY);
    kick();
    axi_rd(RELOAD_HI_ADDR, 32'h0000_0003, RESP_OKAY);
    wait_pulse(60, n);
    chk_data(32'(n), 32'h0000_003d);
    $display("test unlock done");
    // exception mode, normal run: period is reload times divider
    axi_wr(CTRL_ADDR, 8'h01, RESP_OKAY);
    second_pulse(n);
    chk_data(32'(n), 32'h0000_000c);
    chk_data(32'(ev), 32'h0000_0010);
    // exception mode in stop
    @(posedge aclk);
    stop <= 1'h1;
    second_pulse(n);
    chk_data(32'(ev), 32'h0000_0017);
    axi_wr(CTRL_ADDR, 8'h00, RESP_OKAY);
    chk_data(32'(sys_stat), 32'h0000_0003);
    axi_rd(STATUS_ADDR, 32'h0000_0003, RESP_OKAY);
    axi_wr(STATUS_ADDR, 8'h03, RESP_OKAY);
    axi_rd(STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
    $display("test exception done");
    // reset mode, normal run then stop
    rsp <= 1'h1;
    stop <= 1'h0;
    axi_wr(CTRL_ADDR, 8'h01, RESP_OKAY);
    second_pulse(n);
    chk_data(32'(ev), 32'h0000_000a);
    @(posedge aclk);
    stop <= 1'h1;
    second_pulse(n);
    chk_data(32'(ev), 32'h0000_0007);
    $display("test reset mode done");
    // debugger attached holds off every timeout
    @(posedge aclk);
    dbg <= 1'h1;
    repeat (2) @(posedge aclk);
    wait_pulse(60, n);
    chk_data(32'(n), 32'h0000_003d);
    $display("test debug done");
    // second reset mid-run, then always-on enable without refresh
    @(posedge aclk);
    {dbg, stop, rsp, aresetn} <= 4'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(RELOAD_HI_ADDR, 32'h0000_0400, RESP_OKAY);
    axi_rd(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    @(posedge aclk);
    ao <= 1'h1;
    wait_pulse(4200, n);
    chk_data(32'(n >= 4080 && n <= 4110), 32'h0000_0001);
    chk_data(32'(ev), 32'h0000_0010);
    $display("test always-on done");
    summarize();
  end
endmodule : tb_watchdog_timeout_unit

// *** watchdog_timeout_unit.sv ***
// watchdog down-counter with axi4-lite registers and reload unlock
// Functional notes
// - retriggerable one-shot counter; terminal count resets or interrupts the device
// - counter advances only on ticks of its own slow oscillator
// - only off to on; once on it stays on until reset
// - enabled by first refresh instruction or permanently by always-on option
// - clearing oscillator enable stops the oscillator and the counter
// - 16-bit down-counter, reload is high byte above low byte
// - timeout in ms equals reload divided by ten at nominal rate
// - reload resets to 0400h, about 102 ms
// - on first enable load reload value, then count toward zero
// - refresh instruction reloads the counter, counting then resumes
// - under debugger the counter is refreshed continuously, never times out
// - timeout at zero; response option picks exception or reset
// - exception mode, normal run: exception request, reload and continue
// - exception mode in stop: recovery, exception, watchdog and stop flags
// - reset mode, normal run: force reset, set watchdog flag
// - after any reset the counter holds its reset value
// - reset mode in stop: recovery, set watchdog and stop flags
// - reload change needs 55h, AAh to high, then high, then low
// - the two key writes leave the high reload byte unchanged
// - reload writes outside a correct sequence are ignored
// - reading either reload address returns the live counter
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module watchdog_timeout_unit
  import wd_timeout_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned ADDR_W = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system side
  input wire logic refresh_instr,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic always_on_option,
  input wire logic timeout_response_option,
  output logic exception_req,
  output logic reset_req,
  output logic stop_recovery_req,
  output logic wd_flag_set,
  output logic stop_flag_set
);

  // elaboration checks
  if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
    $error("TICK_DIV out of range");
  end
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 14 to 32");
  end

  function automatic logic [13:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = {a[13:2], 2'b00};
  endfunction : word_addr

  function automatic logic is_mapped(input logic [13:0] a);
    is_mapped = (a == CTRL_ADDR) || (a == STATUS_ADDR) ||
                (a == RELOAD_HI_ADDR) || (a == RELOAD_LO_ADDR);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [15:0] reload_q;
  logic [15:0] count_q;
  logic enabled_q;
  logic osc_en_q;
  logic stat_wd_q;
  logic stat_stop_q;
  unlock_state_t lock_q;
  unlock_state_t lock_d;
  logic exc_q, rst_q, rec_q, wdf_q, stf_q;
  logic aw_held_q, w_held_q, bvalid_q, arready_q, rvalid_q;
  logic awready_q, wready_q;
  logic [13:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // write path decode
  wire aw_hs = s_axi_awvalid && !aw_held_q;
  wire w_hs = s_axi_wvalid && !w_held_q;
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_hi = wr_fire && wstrb0_q && (waddr_q == RELOAD_HI_ADDR);
  wire wr_lo = wr_fire && wstrb0_q && (waddr_q == RELOAD_LO_ADDR);
  wire wr_ctrl = wr_fire && wstrb0_q && (waddr_q == CTRL_ADDR);
  wire wr_stat = wr_fire && wstrb0_q && (waddr_q == STATUS_ADDR);
  wire store_hi = wr_hi && (lock_q == OPEN_HIGH);
  wire store_lo = wr_lo && (lock_q == OPEN_LOW);
  wire ar_hs = s_axi_arvalid && arready_q;
  wire [13:0] raddr = word_addr(s_axi_araddr);

  // counter control
  wire tick = tick_q && osc_en_q;
  wire run = enabled_q && tick && !debug_mode;
  wire first_en = !enabled_q && (refresh_instr || always_on_option);
  wire refresh = refresh_instr || (enabled_q && debug_mode);
  wire timeout = run && !refresh && (count_q <= 16'h0001);
  wire resp_reset = timeout_response_option;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator tick divider, one enable pulse per slow period
  always_ff @(posedge aclk) begin
    if (!aresetn || !osc_en_q) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 16'(TICK_DIV - 1));
      tick_cnt_q <= (tick_cnt_q == 16'(TICK_DIV - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable and down-counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enabled_q <= 1'b0;
      count_q <= RELOAD_RESET;
    end else begin
      if (first_en) enabled_q <= 1'b1;
      if (first_en || refresh) begin
        count_q <= reload_q;
      end else if (timeout) begin
        count_q <= reload_q;
      end else if (run) begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  // timeout responses, one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_q <= 1'b0;
      rst_q <= 1'b0;
      rec_q <= 1'b0;
      wdf_q <= 1'b0;
      stf_q <= 1'b0;
    end else begin
      exc_q <= timeout && !resp_reset;
      rst_q <= timeout && resp_reset && !stop_mode;
      rec_q <= timeout && stop_mode;
      wdf_q <= timeout && (stop_mode || resp_reset);
      stf_q <= timeout && stop_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence
  always_comb begin
    lock_d = lock_q;
    if (wr_hi) begin
      unique case (lock_q)
        LOCKED: lock_d = (wbyte_q == UNLOCK_KEY1) ? KEY_SEEN : LOCKED;
        KEY_SEEN: lock_d = (wbyte_q == UNLOCK_KEY2) ? OPEN_HIGH : LOCKED;
        OPEN_HIGH: lock_d = OPEN_LOW;
        OPEN_LOW: lock_d = LOCKED;
        default: lock_d = LOCKED;
      endcase
    end else if (wr_lo) begin
      lock_d = LOCKED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) lock_q <= LOCKED;
    else lock_q <= lock_d;
  end

  // reload and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= RELOAD_RESET;
      osc_en_q <= CTRL_OSC_EN_RESET;
    end else begin
      if (store_hi) reload_q[15:8] <= wbyte_q;
      if (store_lo) reload_q[7:0] <= wbyte_q;
      if (wr_ctrl) osc_en_q <= wbyte_q[CTRL_OSC_EN_BIT];
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_wd_q <= 1'b0;
      stat_stop_q <= 1'b0;
    end else begin
      stat_wd_q <= (stat_wd_q && !(wr_stat && wbyte_q[STAT_WD_BIT])) ||
                   (timeout && (stop_mode || resp_reset));
      stat_stop_q <= (stat_stop_q && !(wr_stat && wbyte_q[STAT_STOP_BIT])) ||
                     (timeout && stop_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      waddr_q <= 14'h0000;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_held_q <= 1'b1;
        awready_q <= 1'b0; // ready flop mirrors the held flag
        waddr_q <= word_addr(s_axi_awaddr);
      end
      if (w_hs) begin
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
        wbyte_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(raddr) ? RESP_OKAY : RESP_SLVERR;
      if (raddr == RELOAD_HI_ADDR || raddr == RELOAD_LO_ADDR) begin
        rdata_q <= {16'h0000, count_q};
      end else if (raddr == CTRL_ADDR) begin
        rdata_q <= {31'h0000_0000, osc_en_q};
      end else if (raddr == STATUS_ADDR) begin
        rdata_q <= {30'h0000_0000, stat_stop_q, stat_wd_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign exception_req = exc_q;
  assign reset_req = rst_q;
  assign stop_recovery_req = rec_q;
  assign wd_flag_set = wdf_q;
  assign stop_flag_set = stf_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  exc_reload_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && !resp_reset |=> exception_req && count_q == $past(reload_q))
    else $error("exception timeout did not fire or reload");

  reset_mode_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && resp_reset && !stop_mode |=> reset_req && wd_flag_set && !exception_req)
    else $error("reset timeout response wrong");

  stop_exc_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && stop_mode && !resp_reset |=> stop_recovery_req && exception_req
      && stop_flag_set && stat_stop_q && stat_wd_q)
    else $error("stop exception response wrong");

  stop_reset_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && stop_mode && resp_reset |=> stop_recovery_req && !reset_req && wd_flag_set)
    else $error("stop reset response wrong");

  refresh_load_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    refresh_instr |=> count_q == $past(reload_q) && enabled_q)
    else $error("refresh did not reload counter");

  debug_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (enabled_q && debug_mode) [*2] |=> !exception_req && !reset_req)
    else $error("timeout under debugger");

  osc_stop_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !osc_en_q && !refresh && !first_en |=> $stable(count_q))
    else $error("counter moved with oscillator off");

  always_on_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    always_on_option |=> enabled_q)
    else $error("always-on option did not enable");

  key_keep_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_hi && (lock_q == LOCKED || lock_q == KEY_SEEN) |=> $stable(reload_q[15:8]))
    else $error("key write changed high byte");

  locked_ignore_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_lo && lock_q != OPEN_LOW |=> $stable(reload_q) && lock_q == LOCKED)
    else $error("low write accepted while locked");

  relock_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    store_lo |=> lock_q == LOCKED && reload_q[7:0] == $past(wbyte_q))
    else $error("low byte write did not relock");

  read_count_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_hs && (raddr == RELOAD_HI_ADDR || raddr == RELOAD_LO_ADDR)
      |=> rvalid_q && rdata_q[15:0] == $past(count_q))
    else $error("reload read did not return counter");

  first_load_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    first_en |=> enabled_q && count_q == $past(reload_q))
    else $error("first enable did not load counter");

  high_store_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    store_hi |=> lock_q == OPEN_LOW && reload_q[15:8] == $past(wbyte_q))
    else $error("open high write not stored");

endmodule : watchdog_timeout_unit

// *** wd_sys_model.sv ***
// stand-in for the reset status register beside the watchdog
`timescale 1ns/100ps
module wd_sys_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wd_flag_set,
  input wire logic stop_flag_set,
  output logic [1:0] rst_status_q
);
  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags, set by the watchdog pulses
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_status_q <= 2'h0;
    end else begin
      rst_status_q <= rst_status_q | {stop_flag_set, wd_flag_set};
    end
  end
endmodule : wd_sys_model

// *** wd_timeout_pkg.sv ***
// constants for the watchdog timeout unit
package wd_timeout_pkg;
  // clock and oscillator rates
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WD_OSC_HZ = 10_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / WD_OSC_HZ;
  // printed register indices, byte address is four times the index
  localparam logic [11:0] RELOAD_HI_IDX = 12'hFF2;
  localparam logic [11:0] RELOAD_LO_IDX = 12'hFF3;
  localparam logic [13:0] RELOAD_HI_ADDR = {RELOAD_HI_IDX, 2'b00};
  localparam logic [13:0] RELOAD_LO_ADDR = {RELOAD_LO_IDX, 2'b00};
  localparam logic [13:0] CTRL_ADDR = 14'h0000;
  localparam logic [13:0] STATUS_ADDR = 14'h0004;
  // field positions
  localparam int unsigned CTRL_OSC_EN_BIT = 0;
  localparam int unsigned STAT_WD_BIT = 0;
  localparam int unsigned STAT_STOP_BIT = 1;
  // reset values and keys
  localparam logic [15:0] RELOAD_RESET = 16'h0400;
  localparam logic CTRL_OSC_EN_RESET = 1'b1;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // unlock sequence states
  typedef enum logic [3:0] {
    LOCKED = 4'b0001,
    KEY_SEEN = 4'b0010,
    OPEN_HIGH = 4'b0100,
    OPEN_LOW = 4'b1000
  } unlock_state_t;
endpackage : wd_timeout_pkg
